/* File: slf_pkg.sv */
/*
 slf_pkg: constants for the serial loader link front end.
 assumes: single 50 MHz system clock, no software registers.
*/
`default_nettype none
package slf_pkg;
   localparam logic [7:0] SLF_SYNC_BYTE = 8'h55; // auto-baud pattern byte
   localparam logic [7:0] SLF_ACK_BYTE = 8'hCC; // good reception / baud ok
   localparam logic [7:0] SLF_NAK_BYTE = 8'h33; // failed reception
   localparam logic [7:0] SLF_ZERO_BYTE = 8'h00; // padding byte
   localparam int SLF_DATA_BITS = 8; // async data bits per char
   localparam int SLF_STOP_BITS = 1; // async stop bits
   localparam int SLF_SYNC_EDGES = 10; // falling edges in the sync pattern
   localparam int SLF_SYNC_BITS = 18; // bit times spanned by those edges
   localparam int SLF_MIN_BIT_CLKS = 32; // baud at most clock/32
   localparam int SLF_DIV_W = 16; // divisor width
   localparam int SLF_CNT_W = 22; // sync span counter width
   localparam int SLF_CLK_PERIOD_NS = 20; // 50 MHz crystal clock
   localparam int SLF_GAP_NS = 1000000; // 1 ms stall ends a sync try
   localparam int SLF_GAP_CLKS = SLF_GAP_NS / SLF_CLK_PERIOD_NS;
   // port selection states
   typedef enum logic [2:0] {
      SLF_PORT_NONE = 3'b001,
      SLF_PORT_ASYNC = 3'b010,
      SLF_PORT_SYNC = 3'b100
   } slf_port_type;
endpackage
`default_nettype wire

/* File: slf_sync_slave.sv */
/*
 slf_sync_slave: synchronous serial slave, clock polarity and phase one.
 assumes: host is master, sclk at most clk_sys/12, inputs already synced.
*/
`timescale 1ns/10ps
`default_nettype none
module slf_sync_slave (
   input wire logic clk_sys,
   input wire logic rst_b,
   input wire logic sclk_s,
   input wire logic cs_b_s,
   input wire logic mosi_s,
   input wire logic [7:0] tx_byte,
   output logic tx_take,
   output logic miso,
   output logic [7:0] rx_byte,
   output logic rx_valid
);
   logic sclk_d; // previous sampled clock
   logic [7:0] shift_in; // incoming bits, msb first
   logic [7:0] shift_out; // outgoing bits
   logic [2:0] bit_cnt; // bits done in byte
   logic fall; // launch edge
   logic rise; // capture edge

   // idle high clock: falling edge launches, rising edge samples
   assign fall = sclk_d & ~sclk_s & ~cs_b_s;
   assign rise = ~sclk_d & sclk_s & ~cs_b_s;

   // edge history follows the synced host clock, no resync needed
   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         sclk_d <= 1'b1;
      end else begin
         sclk_d <= sclk_s;
      end
   end

   // capture and count
   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         shift_in <= 8'h00;
         bit_cnt <= 3'h0;
         rx_byte <= 8'h00;
         rx_valid <= 1'b0;
      end else begin
         rx_valid <= 1'b0;
         if (cs_b_s) begin
            bit_cnt <= 3'h0; // frame end resyncs byte
         end else if (rise) begin
            shift_in <= {shift_in[6:0], mosi_s};
            bit_cnt <= bit_cnt + 3'h1;
            if (bit_cnt == 3'h7) begin
               rx_byte <= {shift_in[6:0], mosi_s};
               rx_valid <= 1'b1;
            end
         end
      end
   end

   // transmit: load at first falling edge of a byte, shift on the rest
   assign tx_take = fall & (bit_cnt == 3'h0);
   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         shift_out <= 8'h00;
         miso <= 1'b0;
      end else if (fall) begin
         if (bit_cnt == 3'h0) begin
            miso <= tx_byte[7];
            shift_out <= {tx_byte[6:0], 1'b0};
         end else begin
            miso <= shift_out[7];
            shift_out <= {shift_out[6:0], 1'b0};
         end
      end
   end
endmodule
`default_nettype wire

/* File: slf_link_front.sv */
/*
 slf_link_front: serial loader link front end, auto-baud async port plus
 synchronous slave port, first used port locked until reset.
 assumes: clk_sys is the crystal clock, pins are asynchronous to it, the
 packet layer supplies tx bytes and ack/nak requests.
*/
// Behaviour
// - first active port kept, other ignored
// - async chars eight data, no parity, one stop
// - measure pulses, program matching baud divisor
// - send 0xCC after successful baud detection
// - sync port clock polarity and phase one
// - host masters sync clock, device is slave
// - loader timing runs from crystal clock directly
// - packet answer 0xCC good, 0x33 bad
// - skip leading zero bytes in host responses
`timescale 1ns/10ps
`default_nettype none
module slf_link_front #(
   parameter int GAP_CLKS = slf_pkg::SLF_GAP_CLKS
) (
   input wire logic clk_sys, // crystal clock, no pll
   input wire logic rst_b,
   input wire logic async_rx, // async receive pin
   output logic async_tx, // async transmit pin
   input wire logic sync_clk, // host serial clock
   input wire logic sync_cs_b, // host frame select, low active
   input wire logic sync_mosi, // host data in
   output logic sync_miso, // data to host
   output logic sync_miso_oe_b, // low while device drives miso
   input wire logic tx_valid, // packet byte to send
   input wire logic [7:0] tx_data,
   output logic tx_ready, // packet byte taken
   input wire logic ack_req, // answer packet good
   input wire logic nak_req, // answer packet bad
   input wire logic wait_resp, // expecting host ack/nak
   output logic [7:0] rx_data, // received byte
   output logic rx_valid, // one-cycle pulse
   output logic resp_valid, // each nonzero byte while wait_resp
   output logic [1:0] port_sel, // 01 async, 10 sync, 00 none
   output logic baud_locked
);
   // two-stage synchronisers for every pin
   logic [1:0] rx_meta, ck_meta, cs_meta, mo_meta;
   logic rx_s, ck_s, cs_s, mo_s;
   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         rx_meta <= 2'h3;
         ck_meta <= 2'h3;
         cs_meta <= 2'h3;
         mo_meta <= 2'h0;
      end else begin
         rx_meta <= {rx_meta[0], async_rx};
         ck_meta <= {ck_meta[0], sync_clk};
         cs_meta <= {cs_meta[0], sync_cs_b};
         mo_meta <= {mo_meta[0], sync_mosi};
      end
   end
   assign rx_s = rx_meta[1];
   assign ck_s = ck_meta[1];
   assign cs_s = cs_meta[1];
   assign mo_s = mo_meta[1];

   slf_pkg::slf_port_type port; // locked port
   logic rx_d; // last rx level
   logic rx_fall;
   logic [slf_pkg::SLF_CNT_W-1:0] span; // clocks since first fall
   logic [3:0] edges; // falling edges seen in sync
   logic [slf_pkg::SLF_CNT_W-1:0] gap; // clocks since last fall
   logic [slf_pkg::SLF_DIV_W-1:0] divisor; // clocks per bit
   logic cc_pend; // confirmation byte owed
   // answer byte pending from ack or nak
   logic resp_pend;
   logic [7:0] resp_byte;
   // async receiver
   logic [slf_pkg::SLF_DIV_W-1:0] rx_cnt;
   logic [3:0] rx_bit;
   logic [7:0] rx_sh;
   logic rx_busy;
   // async transmitter
   logic [slf_pkg::SLF_DIV_W-1:0] tx_cnt;
   logic [3:0] tx_bit;
   logic [9:0] tx_sh;
   logic tx_busy;
   logic tx_go; // start a char
   logic [7:0] out_byte; // byte chosen to send
   // sync slave wiring
   logic s_take, s_valid;
   logic [7:0] s_byte;
   logic a_valid;
   logic [7:0] a_byte;
   logic got_byte;
   logic [7:0] got_data;

   assign rx_fall = rx_d & ~rx_s;

   // port lock: first activity wins until reset
   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         port <= slf_pkg::SLF_PORT_NONE;
      end else begin
         case (port)
            slf_pkg::SLF_PORT_NONE: begin
               if (baud_locked) begin
                  port <= slf_pkg::SLF_PORT_ASYNC;
               end else if (s_valid) begin
                  port <= slf_pkg::SLF_PORT_SYNC;
               end
            end
            default: port <= port; // locked
         endcase
      end
   end
   assign port_sel = {port == slf_pkg::SLF_PORT_SYNC,
                      port == slf_pkg::SLF_PORT_ASYNC};

   // auto-baud: time ten falling edges of 0x55 0x55 (18 bit spans)
   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         rx_d <= 1'b1;
         span <= '0;
         gap <= '0;
         edges <= 4'h0;
         divisor <= '0;
         baud_locked <= 1'b0;
      end else begin
         rx_d <= rx_s;
         if (!baud_locked && port == slf_pkg::SLF_PORT_NONE) begin
            span <= span + 1'b1;
            gap <= gap + 1'b1;
            if (rx_fall) begin
               gap <= '0;
               edges <= edges + 4'h1;
               if (edges == 4'h0) begin
                  span <= '0;
               end
               // last fall of the pattern; span lags it by one clock
               if (edges == 4'(slf_pkg::SLF_SYNC_EDGES - 1)) begin
                  // averaged period over the whole pattern
                  divisor <= slf_pkg::SLF_DIV_W'((span + 1'b1) /
                     slf_pkg::SLF_CNT_W'(slf_pkg::SLF_SYNC_BITS));
                  // faster than clock/32 is rejected, clock/32 kept
                  if (span + 1'b1 >= slf_pkg::SLF_CNT_W'(
                      slf_pkg::SLF_SYNC_BITS * slf_pkg::SLF_MIN_BIT_CLKS)) begin
                     baud_locked <= 1'b1;
                  end else begin
                     edges <= 4'h0;
                  end
               end
            end else if (edges != 4'h0 &&
                         gap >= slf_pkg::SLF_CNT_W'(GAP_CLKS)) begin
               edges <= 4'h0; // stalled try, host will resend
            end
         end
      end
   end

   // async receiver, 8N1 at detected rate, mid-bit sampling
   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         rx_busy <= 1'b0;
         rx_cnt <= '0;
         rx_bit <= 4'h0;
         rx_sh <= 8'h00;
         a_valid <= 1'b0;
         a_byte <= 8'h00;
      end else begin
         a_valid <= 1'b0;
         if (port != slf_pkg::SLF_PORT_ASYNC) begin
            rx_busy <= 1'b0; // other port ignored
         end else if (!rx_busy) begin
            if (rx_fall) begin
               rx_busy <= 1'b1;
               rx_cnt <= divisor >> 1;
               rx_bit <= 4'h0;
            end
         end else if (rx_cnt == '0) begin
            rx_cnt <= divisor - 1'b1;
            rx_bit <= rx_bit + 4'h1;
            if (rx_bit == 4'h0 && rx_s) begin
               rx_busy <= 1'b0; // false start
            end else if (rx_bit ==
                         4'(slf_pkg::SLF_DATA_BITS + 1)) begin
               rx_busy <= 1'b0;
               a_valid <= rx_s; // good stop bit only
               a_byte <= rx_sh;
            end else if (rx_bit != 4'h0) begin
               rx_sh <= {rx_s, rx_sh[7:1]}; // lsb first
            end
         end else begin
            rx_cnt <= rx_cnt - 1'b1;
         end
      end
   end

   // sync slave, gated by the port lock
   slf_sync_slave u_sync (
      .clk_sys(clk_sys),
      .rst_b(rst_b),
      .sclk_s(ck_s),
      .cs_b_s(cs_s | port == slf_pkg::SLF_PORT_ASYNC),
      .mosi_s(mo_s),
      .tx_byte(out_byte),
      .tx_take(s_take),
      .miso(sync_miso),
      .rx_byte(s_byte),
      .rx_valid(s_valid)
   );
   assign sync_miso_oe_b = cs_s | (port != slf_pkg::SLF_PORT_SYNC);

   // unlocked, the sync byte that wins the lock must still come out
   assign got_byte = (port == slf_pkg::SLF_PORT_ASYNC) ? a_valid : s_valid;
   assign got_data = (port == slf_pkg::SLF_PORT_ASYNC) ? a_byte : s_byte;

   // received bytes out; zero padding never counts as a response
   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         rx_data <= 8'h00;
         rx_valid <= 1'b0;
         resp_valid <= 1'b0;
      end else begin
         rx_valid <= got_byte;
         resp_valid <= got_byte & wait_resp &
            (got_data != slf_pkg::SLF_ZERO_BYTE);
         if (got_byte) begin
            rx_data <= got_data;
         end
      end
   end

   // owed bytes: confirmation after lock, answer per packet
   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         cc_pend <= 1'b0;
         resp_pend <= 1'b0;
         resp_byte <= 8'h00;
      end else begin
         if (baud_locked && port == slf_pkg::SLF_PORT_NONE) begin
            cc_pend <= 1'b1;
         end else if (tx_go && cc_pend) begin
            cc_pend <= 1'b0;
         end
         if (ack_req | nak_req) begin
            resp_pend <= 1'b1;
            resp_byte <= ack_req ? slf_pkg::SLF_ACK_BYTE
                                 : slf_pkg::SLF_NAK_BYTE;
         end else if ((tx_go | s_take) && !cc_pend) begin
            resp_pend <= 1'b0;
         end
      end
   end

   // byte priority: confirmation, answer, packet data, else zero padding
   always_comb begin
      if (cc_pend) begin
         out_byte = slf_pkg::SLF_ACK_BYTE;
      end else if (resp_pend) begin
         out_byte = resp_byte;
      end else if (tx_valid) begin
         out_byte = tx_data;
      end else begin
         out_byte = slf_pkg::SLF_ZERO_BYTE;
      end
   end
   assign tx_go = (port == slf_pkg::SLF_PORT_ASYNC) & ~tx_busy &
                  (cc_pend | resp_pend | tx_valid);
   assign tx_ready = ~cc_pend & ~resp_pend & tx_valid &
      (((port == slf_pkg::SLF_PORT_ASYNC) & ~tx_busy) |
       ((port == slf_pkg::SLF_PORT_SYNC) & s_take));

   // async transmitter, 8N1 at detected rate
   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         tx_busy <= 1'b0;
         tx_cnt <= '0;
         tx_bit <= 4'h0;
         tx_sh <= 10'h3FF;
         async_tx <= 1'b1;
      end else if (tx_go) begin
         tx_busy <= 1'b1;
         tx_sh <= {1'b1, out_byte, 1'b0}; // stop, data, start
         tx_cnt <= '0;
         tx_bit <= 4'h0;
      end else if (tx_busy) begin
         if (tx_cnt == '0) begin
            tx_cnt <= divisor - 1'b1;
            async_tx <= tx_sh[0];
            tx_sh <= {1'b1, tx_sh[9:1]};
            tx_bit <= tx_bit + 4'h1;
            if (tx_bit == 4'(slf_pkg::SLF_DATA_BITS +
                slf_pkg::SLF_STOP_BITS + 1)) begin
               tx_busy <= 1'b0;
               async_tx <= 1'b1;
            end
         end else begin
            tx_cnt <= tx_cnt - 1'b1;
         end
      end
   end
endmodule
`default_nettype wire

/* File: slf_link_checker.sv */
/*
 slf_link_checker: port assertions for slf_link_front.
 assumes: bound to the top, one clock domain, rst_b async low.
*/
`timescale 1ns/10ps
`default_nettype none
module slf_link_checker (
   input wire logic clk_sys,
   input wire logic rst_b,
   input wire logic sync_cs_b,
   input wire logic async_tx,
   input wire logic sync_miso_oe_b,
   input wire logic [7:0] rx_data,
   input wire logic rx_valid,
   input wire logic resp_valid,
   input wire logic [1:0] port_sel,
   input wire logic baud_locked
);
   // single domain, so clock and reset are shared
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!rst_b);
   // no async output until the rate is known
   property p_tx_quiet; !baud_locked |-> async_tx; endproperty
   a_tx_quiet: assert property (p_tx_quiet)
      else $error("async_tx active before baud lock");
   // lock stands until reset
   property p_lock_held; baud_locked |=> baud_locked; endproperty
   a_lock_held: assert property (p_lock_held)
      else $error("baud lock dropped");
   // chosen port never changes
   property p_port_held; port_sel != 2'h0 |=> $stable(port_sel); endproperty
   a_port_held: assert property (p_port_held)
      else $error("port selection changed");
   // lock selects the async port next cycle
   property p_lock_port; $rose(baud_locked) |=> port_sel == 2'h1; endproperty
   a_lock_port: assert property (p_lock_port)
      else $error("async port not selected after lock");
   // confirmation start bit follows lock quickly
   property p_cc_start; $rose(baud_locked) |-> ##[1:4] !async_tx; endproperty
   a_cc_start: assert property (p_cc_start)
      else $error("no confirmation start bit");
   // async lock keeps the other port off the wire
   property p_oe_async; port_sel == 2'h1 |-> sync_miso_oe_b; endproperty
   a_oe_async: assert property (p_oe_async)
      else $error("miso driven while async locked");
   // miso released once the frame select is gone
   property p_oe_idle; sync_cs_b [*4] |-> sync_miso_oe_b; endproperty
   a_oe_idle: assert property (p_oe_idle)
      else $error("miso driven without frame select");
   // a response is never a zero byte
   property p_resp_nz; resp_valid |-> rx_data != 8'h00; endproperty
   a_resp_nz: assert property (p_resp_nz)
      else $error("zero byte taken as response");
   // received byte flag is one cycle wide
   property p_rx_pulse; rx_valid |=> !rx_valid; endproperty
   a_rx_pulse: assert property (p_rx_pulse)
      else $error("rx_valid longer than a cycle");
endmodule
bind slf_link_front slf_link_checker slf_link_checker_inst (
   .clk_sys(clk_sys), .rst_b(rst_b), .sync_cs_b(sync_cs_b),
   .async_tx(async_tx), .sync_miso_oe_b(sync_miso_oe_b),
   .rx_data(rx_data), .rx_valid(rx_valid), .resp_valid(resp_valid),
   .port_sel(port_sel), .baud_locked(baud_locked));
`default_nettype wire

/* File: slf_host_model.sv */
/*
 slf_host_model: host side of the loader link, async and clocked ports.
 assumes: tasks are called just after a rising clk_sys edge.
*/
`timescale 1ns/10ps
`default_nettype none
module slf_host_model #(
   parameter int BIT_CLKS = 40, // at least 32 clocks a bit
   parameter int HALF_CLKS = 6 // sclk period 12 clocks
) (
   input wire logic clk_sys,
   input wire logic async_tx,
   output logic async_rx,
   output logic sync_clk,
   output logic sync_cs_b,
   output logic sync_mosi,
   input wire logic sync_miso
);
   // idle levels: line high, clock high
   initial begin
      async_rx = 1'b1;
      sync_clk = 1'b1; // polarity one
      sync_cs_b = 1'b1;
      sync_mosi = 1'b0;
   end
   // one char, lsb first; stop_bit low forces a framing fault
   task automatic send_async(input logic [7:0] b, input logic stop_bit);
      logic [9:0] f;
      f = {stop_bit, b, 1'b0};
      for (int i = 0; i < 10; i++) begin
         @(posedge clk_sys);
         async_rx <= f[i];
         repeat (BIT_CLKS - 1) @(posedge clk_sys);
      end
      @(posedge clk_sys);
      async_rx <= 1'b1;
   endtask
   // one char back; waits two pattern times at most
   task automatic recv_async(output logic [7:0] b);
      int n;
      n = 0;
      b = 8'hXX;
      while (async_tx !== 1'b0 && n < 40 * BIT_CLKS) begin
         @(posedge clk_sys);
         n++;
      end
      if (n < 40 * BIT_CLKS) begin
         repeat (BIT_CLKS / 2) @(posedge clk_sys);
         for (int i = 0; i < 8; i++) begin
            repeat (BIT_CLKS) @(posedge clk_sys);
            b[i] = async_tx;
         end
         repeat (BIT_CLKS) @(posedge clk_sys);
      end
   endtask
   // host is master; data moves on fall, sampled on rise
   task automatic spi_xfer(input logic [7:0] o, output logic [7:0] i);
      @(posedge clk_sys);
      sync_cs_b <= 1'b0;
      repeat (HALF_CLKS) @(posedge clk_sys);
      for (int k = 7; k >= 0; k--) begin
         sync_clk <= 1'b0;
         sync_mosi <= o[k];
         repeat (HALF_CLKS) @(posedge clk_sys);
         sync_clk <= 1'b1;
         i[k] = sync_miso;
         repeat (HALF_CLKS) @(posedge clk_sys);
      end
      sync_cs_b <= 1'b1;
      sync_mosi <= ~sync_mosi; // released line shows no stale bit
      repeat (HALF_CLKS) @(posedge clk_sys);
   endtask
endmodule
`default_nettype wire

/* File: tb_top.sv */
/*
 tb_top: self-checking bench for slf_link_front.
 assumes: host model drives the pins, bench drives the packet side.
*/
`timescale 1ns/10ps
`default_nettype none
module tb_top;
   logic clk_sys, rst_b, async_rx, async_tx, sync_clk, sync_cs_b;
   logic sync_mosi, sync_miso, sync_miso_oe_b, tx_valid, tx_ready;
   logic ack_req, nak_req, wait_resp, rx_valid, resp_valid, baud_locked;
   logic [7:0] tx_data, rx_data, last_rx, b;
   logic [1:0] port_sel;
   int fails, samples_checked, cyc, rx_cnt, resp_cnt, n;
   // short stall limit keeps the run brief
   slf_link_front #(.GAP_CLKS(2000)) slf_link_front_inst (
      .clk_sys(clk_sys), .rst_b(rst_b), .async_rx(async_rx),
      .async_tx(async_tx), .sync_clk(sync_clk), .sync_cs_b(sync_cs_b),
      .sync_mosi(sync_mosi), .sync_miso(sync_miso),
      .sync_miso_oe_b(sync_miso_oe_b), .tx_valid(tx_valid),
      .tx_data(tx_data), .tx_ready(tx_ready), .ack_req(ack_req),
      .nak_req(nak_req), .wait_resp(wait_resp), .rx_data(rx_data),
      .rx_valid(rx_valid), .resp_valid(resp_valid), .port_sel(port_sel),
      .baud_locked(baud_locked));
   slf_host_model #(.BIT_CLKS(40), .HALF_CLKS(6)) host_inst (
      .clk_sys(clk_sys), .async_tx(async_tx), .async_rx(async_rx),
      .sync_clk(sync_clk), .sync_cs_b(sync_cs_b), .sync_mosi(sync_mosi),
      // undriven miso shows the inverse, so a stale bit cannot pass
      .sync_miso(sync_miso_oe_b ? ~sync_miso : sync_miso));
   // 50 MHz
   initial begin
      clk_sys = 1'b0;
      forever #10 clk_sys = ~clk_sys;
   end
   task automatic finish_test;
      if (fails == 0 && samples_checked > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      samples_checked++;
      if (got !== exp) begin
         fails++;
         $display("[FAIL] %0t got %h exp %h", $time, got, exp);
      end
   endtask
   // pulse catchers, tx handshake release, hang guard
   always @(posedge clk_sys) begin
      cyc <= cyc + 1;
      if (rx_valid === 1'b1) begin
         last_rx <= rx_data;
         rx_cnt <= rx_cnt + 1;
      end
      if (resp_valid === 1'b1) resp_cnt <= resp_cnt + 1;
      if (tx_ready === 1'b1) tx_valid <= 1'b0;
      if (cyc == 30000) begin
         fails++;
         finish_test();
      end
   end
   task automatic apply_reset;
      @(posedge clk_sys);
      rst_b <= 1'b0;
      repeat (8) @(posedge clk_sys);
      rst_b <= 1'b1;
      @(posedge clk_sys);
   endtask
   // two pattern bytes, confirmation read back meanwhile
   task automatic t_baud;
      fork
         begin
            host_inst.send_async(8'h55, 1'b1);
            host_inst.send_async(8'h55, 1'b1);
         end
         host_inst.recv_async(b);
      join
      chk(b, slf_pkg::SLF_ACK_BYTE);
      chk({7'h00, baud_locked}, 8'h01);
      chk({6'h00, port_sel}, 8'h01);
   endtask
   // bad stop bit dropped, next char kept, no response unasked
   task automatic t_async_data;
      n = rx_cnt;
      host_inst.send_async(8'hA5, 1'b0);
      host_inst.send_async(8'h3C, 1'b1);
      repeat (4) @(posedge clk_sys);
      chk(8'(rx_cnt - n), 8'h01);
      chk(last_rx, 8'h3C);
      chk(8'(resp_cnt), 8'h00);
   endtask
   // ack beats nak, answers go before data, then a lone nak
   task automatic t_answer;
      ack_req <= 1'b1;
      nak_req <= 1'b1;
      @(posedge clk_sys);
      ack_req <= 1'b0;
      nak_req <= 1'b0;
      // data offered once the answer is queued must wait behind it
      tx_valid <= 1'b1;
      tx_data <= 8'h5A;
      host_inst.recv_async(b);
      chk(b, slf_pkg::SLF_ACK_BYTE);
      host_inst.recv_async(b);
      chk(b, 8'h5A);
      nak_req <= 1'b1;
      @(posedge clk_sys);
      nak_req <= 1'b0;
      host_inst.recv_async(b);
      chk(b, slf_pkg::SLF_NAK_BYTE);
   endtask
   // leading zeros skipped, first nonzero is the response
   task automatic t_resp;
      n = resp_cnt;
      wait_resp <= 1'b1;
      host_inst.send_async(8'h00, 1'b1);
      host_inst.send_async(8'h00, 1'b1);
      host_inst.send_async(8'h33, 1'b1);
      repeat (4) @(posedge clk_sys);
      wait_resp <= 1'b0;
      chk(8'(resp_cnt - n), 8'h01);
      chk(last_rx, 8'h33);
   endtask
   // clocked frame ignored while async port holds the link
   task automatic t_lock_async;
      n = rx_cnt;
      host_inst.spi_xfer(8'h96, b);
      chk(8'(rx_cnt - n), 8'h00);
      chk({6'h00, port_sel}, 8'h01);
   endtask
   // fresh reset, clocked port wins and then owns the link
   task automatic t_sync_port;
      apply_reset();
      host_inst.spi_xfer(8'h96, b);
      chk(last_rx, 8'h96);
      chk({6'h00, port_sel}, 8'h02);
      ack_req <= 1'b1;
      @(posedge clk_sys);
      ack_req <= 1'b0;
      host_inst.spi_xfer(8'h00, b);
      chk(b, slf_pkg::SLF_ACK_BYTE);
      host_inst.spi_xfer(8'h00, b);
      chk(b, slf_pkg::SLF_ZERO_BYTE);
      host_inst.send_async(8'h55, 1'b1);
      host_inst.send_async(8'h55, 1'b1);
      repeat (8) @(posedge clk_sys);
      chk({7'h00, baud_locked}, 8'h00);
   endtask
   initial begin
      rst_b = 1'b0;
      tx_valid = 1'b0;
      tx_data = 8'h00;
      ack_req = 1'b0;
      nak_req = 1'b0;
      wait_resp = 1'b0;
      {fails, samples_checked, cyc, rx_cnt, resp_cnt} = '0;
      apply_reset();
      t_baud();
      t_async_data();
      t_answer();
      t_resp();
      t_lock_async();
      t_sync_port();
      finish_test();
   end
endmodule
`default_nettype wire
